/* hw/iisr_top.v */
// Builds the interrupt condition code and interrupt identification word.
// Assumes the channel pulses int_accept for one clk when it takes the interrupt.
`include "iisr_consts.vh"

module iisr_top
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        cycle_steal_mode,
    input  wire [7:0]  device_address,
    input  wire [7:0]  group_low_address,
    input  wire        ctrl_busy_reported,
    input  wire        op_end,
    input  wire        pci_block_done,
    input  wire [7:0]  pci_block_id,
    input  wire        attention,
    input  wire        exception_only,
    input  wire        suppress_exception_flag,
    input  wire        exception_suppressed,
    input  wire        start_cmd,
    input  wire        ev_status_avail,
    input  wire        ev_delayed_reject,
    input  wire        ev_incorrect_length,
    input  wire        ev_dcb_spec_check,
    input  wire        ev_storage_data_check,
    input  wire        ev_invalid_address,
    input  wire        ev_iface_check,
    input  wire        storage_word_bad_parity,
    input  wire        int_accept,
    input  wire [15:0] out_data_in,
    output reg  [15:0] io_data_out_q,
    output reg         io_data_valid_q,
    output wire        op_terminate,
    output reg         int_request_q,
    output reg  [2:0]  condition_code_q,
    output reg  [15:0] int_id_word_q
);

    wire [7:0] interrupt_status_byte;
    reg        ctrl_pend_q;
    reg        suppressed_q;
    reg        exc_only_q;
    reg        ctrl_busy_d;
    reg [2:0]  cc_d;
    reg [7:0]  info_d;
    reg [7:0]  addr_d;
    reg        fire_d;
    wire       errors_seen;
    wire       err_event;

    // =====================================================
    // Status byte accumulation
    iisr_status_merge u_merge
    (
        .clk                     (clk),
        .sys_rst                 (sys_rst),
        .clear                   (int_accept),
        .cycle_steal_mode        (cycle_steal_mode),
        .suppress_exception_flag (suppress_exception_flag),
        .ev_status_avail         (ev_status_avail),
        .ev_delayed_reject       (ev_delayed_reject),
        .ev_incorrect_length     (ev_incorrect_length),
        .ev_dcb_spec_check       (ev_dcb_spec_check),
        .ev_storage_data_check   (ev_storage_data_check & cycle_steal_mode),
        .ev_invalid_address      (ev_invalid_address),
        .ev_iface_check          (ev_iface_check),
        .status_q                (interrupt_status_byte)
    );

    assign errors_seen = (interrupt_status_byte != 8'h00) | exc_only_q;

    // Status available and delayed reject terminate the operation in any mode; other errors only in cycle-steal mode
    assign err_event = ev_status_avail | ev_delayed_reject
                     | (ev_incorrect_length & ~suppress_exception_flag & cycle_steal_mode)
                     | ((ev_dcb_spec_check | ev_storage_data_check | ev_invalid_address
                        | ev_iface_check) & cycle_steal_mode);
    assign op_terminate = err_event;

    // =====================================================
    // Controller busy memory and suppressed-exception tracking
    always @*
    begin
        ctrl_busy_d = ctrl_pend_q | ctrl_busy_reported;
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_pend_q  <= 1'b0;
            suppressed_q <= 1'b0;
            exc_only_q   <= 1'b0;
        end
        else
        begin
            // Busy report wins over the clear on a controller end
            if (ctrl_busy_reported)
                ctrl_pend_q <= 1'b1;
            else if (fire_d && cc_d == `IISR_CC_CTRL_END)
                ctrl_pend_q <= 1'b0;
            // Suppressed exception remembered since the last start command
            if (exception_suppressed)
                suppressed_q <= 1'b1;
            else if (start_cmd)
                suppressed_q <= 1'b0;
            if (exception_only)
                exc_only_q <= 1'b1;
            else if (int_accept)
                exc_only_q <= 1'b0;
        end
    end

    // =====================================================
    // Interrupt selection and word assembly
    //
    // Only one interrupt is built at a time. While a request stands,
    // new end or block events are not turned into interrupts; the
    // status bits behind them still gather in the merge block.
    //
    // Priority, highest first:
    //   ending with errors      -> exception, status byte as info
    //   ending without errors   -> device end, optional permissive flag
    //   flagged block done      -> program interrupt, block identifier
    //   pending controller end  -> lowest group address, zero info
    //
    // Attention adds four to any code but controller end, since a
    // controller speaks for the group and not for one device.
    //
    // Hazard: an error event in the same cycle as op_end is not yet in
    // the status byte, so it would be reported as a device end. Callers
    // must raise status events at least one cycle before op_end.
    always @*
    begin
        fire_d = 1'b0;
        cc_d   = `IISR_CC_DEVICE_END;
        info_d = 8'h00;
        addr_d = device_address;
        if (!int_request_q)
        begin
            if (op_end && errors_seen)
            begin
                fire_d = 1'b1;
                cc_d   = `IISR_CC_EXCEPTION;
                info_d = interrupt_status_byte;
            end
            else if (op_end)
            begin
                fire_d = 1'b1;
                cc_d   = `IISR_CC_DEVICE_END;
                if (suppress_exception_flag && suppressed_q)
                    info_d[`IISR_SB_PNE] = 1'b1;
            end
            else if (pci_block_done)
            begin
                fire_d = 1'b1;
                cc_d   = `IISR_CC_PCI;
                info_d = pci_block_id;
            end
            else if (ctrl_pend_q && !ctrl_busy_reported)
            begin
                fire_d = 1'b1;
                cc_d   = `IISR_CC_CTRL_END;
                info_d = 8'h00;
                addr_d = group_low_address;
            end
            if (fire_d && attention && cc_d != `IISR_CC_CTRL_END)
                cc_d[`IISR_CC_ATTN_BIT] = 1'b1;
        end
    end

    // Request held until accepted; acceptance clears the presented word
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_request_q    <= 1'b0;
            condition_code_q <= `IISR_RST_CC;
            int_id_word_q    <= {`IISR_RST_BYTE, `IISR_RST_ADDR};
        end
        else if (int_request_q && int_accept)
        begin
            int_request_q    <= 1'b0;
            condition_code_q <= `IISR_RST_CC;
            int_id_word_q    <= {`IISR_RST_BYTE, `IISR_RST_ADDR};
        end
        else if (fire_d)
        begin
            int_request_q    <= 1'b1;
            condition_code_q <= cc_d;
            int_id_word_q    <= {info_d, addr_d};
        end
    end

    // =====================================================
    // Output data path; a bad-parity storage word is never driven
    // The last good word is held, so the bus never shows the bad one;
    // the valid flag drops for that cycle and the channel ignores the
    // held value. No machine check is raised from here.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            io_data_out_q   <= 16'h0000;
            io_data_valid_q <= 1'b0;
        end
        else
        begin
            io_data_valid_q <= cycle_steal_mode & ~storage_word_bad_parity;
            if (cycle_steal_mode && !storage_word_bad_parity)
                io_data_out_q <= out_data_in;
        end
    end

endmodule // iisr_top

/* hw/iisr_consts.vh */
// Constants for the interrupt status reporting block.
// Assumes inclusion by bare name from the design files.
`ifndef IISR_CONSTS_VH
`define IISR_CONSTS_VH
// =====================================================
// Interrupt condition codes
`define IISR_CC_CTRL_END    3'h0
`define IISR_CC_PCI         3'h1
`define IISR_CC_EXCEPTION   3'h2
`define IISR_CC_DEVICE_END  3'h3
`define IISR_CC_ATTN_BIT    2
// =====================================================
// Status byte bit positions (bit 7 is the MSB of the byte, bit 0 the LSB)
`define IISR_SB_STATUS_AVAIL 7
`define IISR_SB_DELAYED_REJ  6
`define IISR_SB_INCORR_LEN   5
`define IISR_SB_DCB_SPEC     4
`define IISR_SB_STOR_DATA    3
`define IISR_SB_INV_ADDR     2
`define IISR_SB_UNUSED       1
`define IISR_SB_IFACE_CHECK  0
`define IISR_SB_PNE          7
// =====================================================
// Reset values
`define IISR_RST_BYTE  8'h00
`define IISR_RST_ADDR  8'h00
`define IISR_RST_CC    3'h0
`endif

/* hw/iisr_status_merge.v */
// Status byte accumulator: gathers error bits of the running operation.
// Assumes one-cycle event pulses from the device logic on clk.
`include "iisr_consts.vh"

module iisr_status_merge
(
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       clear,
    input  wire       cycle_steal_mode,
    input  wire       suppress_exception_flag,
    input  wire       ev_status_avail,
    input  wire       ev_delayed_reject,
    input  wire       ev_incorrect_length,
    input  wire       ev_dcb_spec_check,
    input  wire       ev_storage_data_check,
    input  wire       ev_invalid_address,
    input  wire       ev_iface_check,
    output reg  [7:0] status_q
);

    reg [7:0] set_vec;

    // =====================================================
    // Set vector per format
    always @*
    begin
        set_vec = 8'h00;
        set_vec[`IISR_SB_STATUS_AVAIL] = ev_status_avail;
        set_vec[`IISR_SB_DELAYED_REJ]  = ev_delayed_reject;
        if (cycle_steal_mode)
        begin
            set_vec[`IISR_SB_INCORR_LEN]  = ev_incorrect_length & ~suppress_exception_flag;
            set_vec[`IISR_SB_DCB_SPEC]    = ev_dcb_spec_check;
            set_vec[`IISR_SB_STOR_DATA]   = ev_storage_data_check;
            set_vec[`IISR_SB_INV_ADDR]    = ev_invalid_address;
            set_vec[`IISR_SB_IFACE_CHECK] = ev_iface_check;
        end
        set_vec[`IISR_SB_UNUSED] = 1'b0;
    end

    // Sticky bits; a new event wins over a clear in the same cycle
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            status_q <= `IISR_RST_BYTE;
        else
            status_q <= (clear ? 8'h00 : status_q) | set_vec;
    end

endmodule // iisr_status_merge

/* verif/iisr_top_props.sv */
// Checker for the interrupt condition code and identification word.
// Assumes binding to iisr_top, one clock clk and reset sys_rst.
module iisr_top_props
(
    input logic        clk,
    input logic        sys_rst,
    input logic        cycle_steal_mode,
    input logic [7:0]  device_address,
    input logic [7:0]  group_low_address,
    input logic [7:0]  pci_block_id,
    input logic        ev_invalid_address,
    input logic        storage_word_bad_parity,
    input logic        int_accept,
    input logic        io_data_valid_q,
    input logic        op_terminate,
    input logic        int_request_q,
    input logic [2:0]  condition_code_q,
    input logic [15:0] int_id_word_q
);
    // =========================================
    // Clock and reset for every property
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // =========================================
    // Interrupt word, request handshake, data valid on bad parity and termination
    a_ce_low_addr: assert property (int_request_q && condition_code_q == 3'h0
        |-> int_id_word_q == {8'h00, group_low_address}) else $error("controller end word wrong");
    a_dev_own_addr: assert property (int_request_q && condition_code_q != 3'h0
        |-> int_id_word_q[7:0] == device_address) else $error("device address wrong");
    a_pci_block_id: assert property (int_request_q && condition_code_q[1:0] == 2'h1
        |-> int_id_word_q[15:8] == pci_block_id) else $error("block identifier wrong");
    a_exc_not_zero: assert property (int_request_q && condition_code_q[1:0] == 2'h2 && cycle_steal_mode
        |-> int_id_word_q[15:8] != 8'h00) else $error("zero status byte");
    a_unused_bit_zero: assert property (int_request_q |-> !int_id_word_q[9])
        else $error("unused status bit set");
    a_req_stands: assert property (int_request_q && !int_accept
        |=> int_request_q && $stable(int_id_word_q) && $stable(condition_code_q)) else $error("request dropped");
    a_accept_clears: assert property (int_request_q && int_accept
        |=> !int_request_q && int_id_word_q == 16'h0000) else $error("status not cleared");
    a_bad_parity_held: assert property (storage_word_bad_parity |=> !io_data_valid_q)
        else $error("bad parity data driven");
    a_addr_terminates: assert property (ev_invalid_address && cycle_steal_mode |-> op_terminate)
        else $error("no termination");
endmodule // iisr_top_props

bind iisr_top iisr_top_props u_props (.clk, .sys_rst, .cycle_steal_mode, .device_address, .group_low_address,
    .pci_block_id, .ev_invalid_address, .storage_word_bad_parity, .int_accept, .io_data_valid_q, .op_terminate,
    .int_request_q, .condition_code_q, .int_id_word_q);

/* verif/iisr_chan_model.sv */
// Channel model that accepts a standing interrupt request.
// Assumes request stays up until the accept pulse is seen.
module iisr_chan_model
(
    input  logic       clk,
    input  logic       sys_rst,
    input  logic       int_request_q,
    input  logic [3:0] dly,
    output logic       int_accept
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_q;
    // One accept pulse per request, after dly cycles of waiting
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_q     <= 4'h0;
            int_accept <= 1'b0;
        end
        else if (int_accept || !int_request_q)
        begin
            wait_q     <= 4'h0;
            int_accept <= 1'b0;
        end
        else if (wait_q == dly)
            int_accept <= 1'b1;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule // iisr_chan_model

/* verif/iisr_top_tb_top.sv */
// Self-checking bench for the interrupt status block.
// Assumes the channel model answers every request.
module iisr_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, sys_rst = 1, cycle_steal_mode = 0, ctrl_busy_reported = 0, op_end = 0, pci_block_done = 0;
    logic attention = 0, suppress_exception_flag = 0, exception_suppressed = 0, start_cmd = 0;
    logic storage_word_bad_parity = 0, int_accept, io_data_valid_q, op_terminate, int_request_q;
    logic [7:0] device_address = 8'h2C, group_low_address = 8'h28, pci_block_id = 8'h00, evq = 8'h00;
    logic [15:0] out_data_in = 16'h0000, io_data_out_q, int_id_word_q;
    logic [3:0] dly = 4'h0;
    logic [2:0] condition_code_q;
    wire exception_only, ev_status_avail, ev_delayed_reject, ev_incorrect_length, ev_dcb_spec_check;
    wire ev_storage_data_check, ev_invalid_address, ev_iface_check;
    int bad_count = 0, comparisons = 0, cyc = 0;
    // Event vector, highest bit first, status bits in byte order
    assign {exception_only, ev_status_avail, ev_delayed_reject, ev_incorrect_length, ev_dcb_spec_check,
            ev_storage_data_check, ev_invalid_address, ev_iface_check} = evq;
    iisr_top DUT (.*);
    iisr_chan_model u_chan (.*);
    // Clock and hang limit
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            test_done();
        end
    end
    // =========================================
    // Shared tasks
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Events, then trigger, then check the word and its clearing
    task automatic irq(input logic [7:0] e, input int kind, input logic att, input logic [2:0] cc,
                       input logic [7:0] b);
        int n;
        @(posedge clk);
        evq       <= e;
        attention <= att;
        @(negedge clk);
        chk("terminate", {15'h0, op_terminate},
            {15'h0, |(e & (cycle_steal_mode ? (suppress_exception_flag ? 8'h6F : 8'h7F) : 8'h60))});
        @(posedge clk);
        evq                <= 8'h00;
        op_end             <= (kind == 0);
        pci_block_done     <= (kind == 1);
        ctrl_busy_reported <= (kind == 2);
        @(posedge clk);
        {op_end, pci_block_done, ctrl_busy_reported} <= 3'h0;
        n = 0;
        @(negedge clk);
        while (int_request_q !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chk("condition_code", {13'h0, condition_code_q}, {13'h0, cc});
        chk("id_word", int_id_word_q, {b, (cc == 3'h0) ? group_low_address : device_address});
        while (int_request_q !== 1'b0 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk("cleared_word", int_id_word_q, 16'h0000);
    endtask
    // =========================================
    // Scenarios
    task automatic t_ctrl_end();
        irq(8'h00, 2, 1'b1, 3'h0, 8'h00);
    endtask
    task automatic t_cs_errors();
        logic [7:0] e;
        @(posedge clk);
        cycle_steal_mode <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            e = 8'h01 << i;
            irq(e, 0, 1'b0, 3'h2, {e[6:1], 1'b0, e[0]});
        end
        irq(8'h7F, 0, 1'b1, 3'h6, 8'hFD);
    endtask
    task automatic t_dev_end();
        irq(8'h00, 0, 1'b0, 3'h3, 8'h00);
        irq(8'h00, 0, 1'b1, 3'h7, 8'h00);
    endtask
    task automatic t_pci();
        @(posedge clk);
        dly          <= 4'h6;
        pci_block_id <= 8'hA5;
        irq(8'h00, 1, 1'b0, 3'h1, 8'hA5);
        irq(8'h00, 1, 1'b1, 3'h5, 8'hA5);
    endtask
    task automatic t_pde();
        @(posedge clk);
        suppress_exception_flag <= 1'b1;
        start_cmd               <= 1'b1;
        @(posedge clk);
        start_cmd            <= 1'b0;
        exception_suppressed <= 1'b1;
        @(posedge clk);
        exception_suppressed <= 1'b0;
        irq(8'h00, 0, 1'b0, 3'h3, 8'h80);
        @(posedge clk);
        start_cmd <= 1'b1;
        @(posedge clk);
        start_cmd <= 1'b0;
        irq(8'h10, 0, 1'b0, 3'h3, 8'h00);
        @(posedge clk);
        suppress_exception_flag <= 1'b0;
    endtask
    task automatic t_dpc();
        @(posedge clk);
        cycle_steal_mode <= 1'b0;
        irq(8'h80, 0, 1'b0, 3'h2, 8'h00);
        irq(8'h40, 0, 1'b0, 3'h2, 8'h80);
        irq(8'h20, 0, 1'b0, 3'h2, 8'h40);
    endtask
    task automatic t_parity();
        @(posedge clk);
        cycle_steal_mode        <= 1'b1;
        out_data_in             <= 16'hA55A;
        storage_word_bad_parity <= 1'b1;
        @(posedge clk);
        storage_word_bad_parity <= 1'b0;
        @(negedge clk);
        chk("data_valid", {15'h0, io_data_valid_q}, 16'h0000);
        @(negedge clk);
        chk("data_valid", {15'h0, io_data_valid_q}, 16'h0001);
        chk("data_out", io_data_out_q, 16'hA55A);
    endtask
    // Reset, then every scenario in turn
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_ctrl_end();
        t_cs_errors();
        t_dev_end();
        t_pci();
        t_pde();
        t_dpc();
        t_parity();
        test_done();
    end
endmodule // iisr_top_tb_top
